// ===== hdl/dioc_cnt_if.sv
// Purpose: carrier between the register block and one counter unit
// Assumes: all signals on ref_clk
// Notes:   ctrl side selects lines and mode, unit side returns the count
`timescale 1ns/1ps
interface dioc_cnt_if;
  dioc_pkg::dioc_mode_t mode;
  logic                 a_en;
  logic                 b_en;
  logic                 r_en;
  logic                 a;
  logic                 b;
  logic                 r;
  logic [31:0]          count;

  modport ctrl (output mode, a_en, b_en, r_en, a, b, r, input count);
  modport unit (input mode, a_en, b_en, r_en, a, b, r, output count);
endinterface

// ===== hdl/dioc_counter.sv
// Purpose: one 32-bit counter with simple, up/down and quadrature modes
// Assumes: a, b, r already synchronised to ref_clk
// Notes:   counting wraps modulo 2^32, which covers both ranges
`timescale 1ns/1ps
`include "dioc_defines.svh"
module dioc_counter (
  // clock, reset and clock enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // counter carrier
  dioc_cnt_if.unit cnt
);

  dioc_pkg::dioc_cnt_state_t q;
  dioc_pkg::dioc_cnt_state_t d;
  logic                      a_in;
  logic                      b_in;
  logic                      a_rise;
  logic                      quad_step;
  logic                      quad_up;

  assign a_in      = cnt.a_en & cnt.a;
  assign b_in      = cnt.b_en & cnt.b;
  assign a_rise    = a_in & ~q.a_prev;
  assign quad_step = (a_in ^ q.a_prev) ^ (b_in ^ q.b_prev);
  assign quad_up   = a_in ^ q.b_prev;

  always_comb begin
    d        = q;
    d.a_prev = a_in;
    d.b_prev = b_in;
    if (cnt.r_en && cnt.r) begin
      d.count = '0; // R8
    end else if (cnt.a_en) begin // R10
      case (cnt.mode)
        dioc_pkg::DIOC_MODE_SIMPLE: begin
          if (a_rise) d.count = q.count + 32'h0000_0001; // R6 R7
        end
        dioc_pkg::DIOC_MODE_UPDOWN: begin
          // second line high counts down; signed wrap comes from modulo arithmetic
          if (a_rise && b_in) d.count = q.count - 32'h0000_0001; // R12
          else if (a_rise) d.count = q.count + 32'h0000_0001; // R12
        end
        dioc_pkg::DIOC_MODE_QUAD: begin
          // one line changing per sample; both changing is an illegal jump and is dropped
          if (quad_step && quad_up) d.count = q.count + 32'h0000_0001; // R9
          else if (quad_step) d.count = q.count - 32'h0000_0001; // R9
        end
        default: d.count = q.count;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{a_prev: 1'b0, b_prev: 1'b0, count: 32'h0000_0000};
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign cnt.count = q.count;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_clr;
    clk_en && cnt.r_en && cnt.r;
  endsequence

  AST_RST_CLEAR: assert property (s_clr |=> cnt.count == 32'h0000_0000) // R8
    else $error("counter not cleared by external reset");
  AST_IDLE_HOLD: assert property (clk_en && !cnt.a_en && !(cnt.r_en && cnt.r) |=> $stable(cnt.count)) // R10
    else $error("unassigned counter changed");
  AST_SIMPLE_INC: assert property (clk_en && !(cnt.r_en && cnt.r) && cnt.a_en
      && cnt.mode == dioc_pkg::DIOC_MODE_SIMPLE && a_rise
      |=> cnt.count == $past(cnt.count) + 32'h0000_0001) // R6
    else $error("simple mode did not increment");
  AST_WRAP: assert property (clk_en && !(cnt.r_en && cnt.r) && cnt.a_en
      && cnt.mode == dioc_pkg::DIOC_MODE_SIMPLE && a_rise && cnt.count == 32'hffff_ffff
      |=> cnt.count == 32'h0000_0000) // R7
    else $error("counter did not wrap to minimum");
  AST_UPDOWN_DN: assert property (clk_en && !(cnt.r_en && cnt.r) && cnt.a_en
      && cnt.mode == dioc_pkg::DIOC_MODE_UPDOWN && a_rise && b_in
      |=> cnt.count == $past(cnt.count) - 32'h0000_0001) // R12
    else $error("up/down mode did not count down");
  AST_QUAD_UP: assert property (clk_en && !(cnt.r_en && cnt.r) && cnt.a_en
      && cnt.mode == dioc_pkg::DIOC_MODE_QUAD && quad_step && quad_up
      |=> cnt.count == $past(cnt.count) + 32'h0000_0001) // R9
    else $error("quadrature forward step not counted up");

endmodule // dioc_counter

// ===== hdl/dioc_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the digital i/o block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   included by its bare name
`ifndef DIOC_DEFINES_SVH
`define DIOC_DEFINES_SVH

// register byte offsets
`define DIOC_OFS_DIR      12'h000
`define DIOC_OFS_OUT      12'h004
`define DIOC_OFS_IN_SCAN  12'h008
`define DIOC_OFS_IN_LIVE  12'h00c
`define DIOC_OFS_CFG0     12'h010
`define DIOC_OFS_VAL0     12'h020
`define DIOC_OFS_STRIDE   12'h004

// geometry
`define DIOC_LINES        32
`define DIOC_GROUPS       4
`define DIOC_GROUP_W      8
`define DIOC_NCNT         3
`define DIOC_CNT_W        32

// counter configuration fields
`define DIOC_CFG_MODE_LSB 0
`define DIOC_CFG_A_EN     2
`define DIOC_CFG_B_EN     3
`define DIOC_CFG_R_EN     4
`define DIOC_CFG_A_SEL    8
`define DIOC_CFG_B_SEL    16
`define DIOC_CFG_R_SEL    24
`define DIOC_SEL_W        5

// reset values: port a input, port b output
`define DIOC_DIR_RST      4'hc
`define DIOC_OUT_RST      32'h0000_0000
`define DIOC_CFG_RST      32'h0000_0000

// timing
`define DIOC_CLK_PERIOD_PS   10000
`define DIOC_PULSE_MAX_KHZ   16000
`define DIOC_PULSE_PERIOD_PS (1000000000 / `DIOC_PULSE_MAX_KHZ)
`define DIOC_PULSE_MIN_CYC   ((`DIOC_PULSE_PERIOD_PS + `DIOC_CLK_PERIOD_PS - 1) / `DIOC_CLK_PERIOD_PS)

`endif

// ===== hdl/dioc_pkg.sv
// Purpose: types shared by the digital i/o block
// Assumes: constants come from dioc_defines.svh
// Notes:   no constants here besides type encodings
package dioc_pkg;

  typedef enum logic [1:0] {
    DIOC_MODE_SIMPLE = 2'h0,
    DIOC_MODE_UPDOWN = 2'h1,
    DIOC_MODE_QUAD   = 2'h2
  } dioc_mode_t;

  typedef struct packed {
    logic        a_prev;
    logic        b_prev;
    logic [31:0] count;
  } dioc_cnt_state_t;

  typedef struct packed {
    logic [3:0]       dir;
    logic [31:0]      out;
    logic [31:0]      sync1;
    logic [31:0]      sync2;
    logic [31:0]      scan;
    logic [2:0][31:0] cfg;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } dioc_regs_t;

endpackage

// ===== hdl/dioc_top.sv
// Purpose: two 16-line bidirectional ports, scan capture and three counters behind apb
// Assumes: dio_in comes from pins; scan_strobe comes from acquisition logic on ref_clk
// Notes:   port a is lines 15:0, port b is lines 31:16; direction bit 1 drives the group
`timescale 1ns/1ps
`include "dioc_defines.svh"
// Overview of operation
// R1: two 16-line ports, each line in or out, direction per eight-line group.
// R2: after reset port A is all inputs, port B all outputs.
// R3: input lines are captured on the same strobe as the analog scan.
// R4: three independent counters, each holding a 32-bit count.
// R5: each counter's A, B and reset lines are software-selected from any line.
// R6: simple mode increments on each rising edge of line A.
// R7: counting past the top of the range wraps to its minimum.
// R8: an assigned reset line clears its counter at any time.
// R9: quadrature mode decodes A/B phase to count up or down.
// R10: a counter without its A line assigned stays inactive.
// R11: software sets source line groups to input before assigning them.
// R12: up/down and quadrature counts are signed two's complement, simple is unsigned.
module dioc_top (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // acquisition
  input  wire logic        scan_strobe,
  // digital lines
  input  wire logic [31:0] dio_in,
  output logic      [31:0] dio_out,
  output logic      [31:0] dio_oe
);

  localparam dioc_pkg::dioc_regs_t REGS_RST = '{
    dir:     `DIOC_DIR_RST,
    out:     `DIOC_OUT_RST,
    sync1:   32'h0000_0000,
    sync2:   32'h0000_0000,
    scan:    32'h0000_0000,
    cfg:     {3{`DIOC_CFG_RST}},
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

  dioc_pkg::dioc_regs_t q;
  dioc_pkg::dioc_regs_t d;
  logic [2:0][31:0]     cnt_val;
  logic                 setup;
  logic                 wr_fire;
  logic                 acc_err;
  logic [31:0]          rd_val;

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // pick one line out of the 32 port lines
  function automatic logic pick(input logic [31:0] lines, input logic [4:0] sel);
    return lines[sel];
  endfunction

  // counter register index for an address, 3 when none
  function automatic logic [1:0] cnt_idx(input logic [11:0] a, input logic [11:0] base);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 0; i < `DIOC_NCNT; i++) begin
      if (a == base + 12'(i) * `DIOC_OFS_STRIDE) r = 2'(i);
    end
    return r;
  endfunction

  // expand the four group bits to one enable per line
  function automatic logic [31:0] grp_oe(input logic [3:0] dir);
    logic [31:0] r;
    for (int g = 0; g < `DIOC_GROUPS; g++) begin
      r[g*`DIOC_GROUP_W +: `DIOC_GROUP_W] = {`DIOC_GROUP_W{dir[g]}};
    end
    return r;
  endfunction

  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && q.pready && pwrite && !q.pslverr;

  // decode of the setup cycle: read value and error answer
  always_comb begin
    rd_val  = 32'h0000_0000;
    acc_err = 1'b0;
    if (paddr == `DIOC_OFS_DIR) begin
      rd_val = {28'h000_0000, q.dir};
    end else if (paddr == `DIOC_OFS_OUT) begin
      rd_val = q.out;
    end else if (paddr == `DIOC_OFS_IN_SCAN) begin
      rd_val  = q.scan;
      acc_err = pwrite;
    end else if (paddr == `DIOC_OFS_IN_LIVE) begin
      rd_val  = q.sync2;
      acc_err = pwrite;
    end else if (cnt_idx(paddr, `DIOC_OFS_CFG0) != 2'h3) begin
      rd_val = q.cfg[cnt_idx(paddr, `DIOC_OFS_CFG0)];
    end else if (cnt_idx(paddr, `DIOC_OFS_VAL0) != 2'h3) begin
      rd_val  = cnt_val[cnt_idx(paddr, `DIOC_OFS_VAL0)];
      acc_err = pwrite;
    end else begin
      acc_err = 1'b1;
    end
  end

  always_comb begin
    d       = q;
    // first stage is read only by the second
    d.sync1 = dio_in;
    d.sync2 = q.sync1;
    if (scan_strobe) d.scan = q.sync2; // R3
    d.pready = setup;
    if (setup) begin
      d.pslverr = acc_err;
      d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end else if (!psel) begin
      d.pslverr = 1'b0;
      d.prdata  = 32'h0000_0000;
    end
    if (wr_fire) begin
      if (paddr == `DIOC_OFS_DIR) begin
        if (pstrb[0]) d.dir = pwdata[3:0]; // R1
      end else if (paddr == `DIOC_OFS_OUT) begin
        d.out = merge(q.out, pwdata, pstrb);
      end else if (cnt_idx(paddr, `DIOC_OFS_CFG0) != 2'h3) begin
        d.cfg[cnt_idx(paddr, `DIOC_OFS_CFG0)] =
          merge(q.cfg[cnt_idx(paddr, `DIOC_OFS_CFG0)], pwdata, pstrb); // R5
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= REGS_RST; // R2
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign pready  = q.pready;
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;
  assign dio_out = q.out;
  assign dio_oe  = grp_oe(q.dir); // R1

  dioc_cnt_if cnt_bus [`DIOC_NCNT] ();

  genvar gi;
  generate
    for (gi = 0; gi < `DIOC_NCNT; gi++) begin : g_cnt
      // line routing reads the synchronised copy only
      assign cnt_bus[gi].mode = dioc_pkg::dioc_mode_t'(q.cfg[gi][`DIOC_CFG_MODE_LSB +: 2]);
      assign cnt_bus[gi].a_en = q.cfg[gi][`DIOC_CFG_A_EN]; // R10
      assign cnt_bus[gi].b_en = q.cfg[gi][`DIOC_CFG_B_EN];
      assign cnt_bus[gi].r_en = q.cfg[gi][`DIOC_CFG_R_EN]; // R8
      assign cnt_bus[gi].a = pick(q.sync2, q.cfg[gi][`DIOC_CFG_A_SEL +: `DIOC_SEL_W]); // R5
      assign cnt_bus[gi].b = pick(q.sync2, q.cfg[gi][`DIOC_CFG_B_SEL +: `DIOC_SEL_W]); // R5
      assign cnt_bus[gi].r = pick(q.sync2, q.cfg[gi][`DIOC_CFG_R_SEL +: `DIOC_SEL_W]); // R5
      assign cnt_val[gi]   = cnt_bus[gi].count;

      dioc_counter u_cnt ( // R4
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .cnt     (cnt_bus[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_setup;
    clk_en && psel && !penable;
  endsequence

  sequence s_dir_write;
    clk_en && psel && penable && pready && pwrite && !pslverr
      && paddr == `DIOC_OFS_DIR && pstrb[0];
  endsequence

  AST_POWERUP_DIR: assert property ($rose(resetn) |-> dio_oe == 32'hffff_0000) // R2
    else $error("power-up direction wrong");
  AST_GROUPS_UNIFORM: assert property (
      dio_oe[7:0] inside {8'h00, 8'hff} && dio_oe[15:8] inside {8'h00, 8'hff}
      && dio_oe[23:16] inside {8'h00, 8'hff} && dio_oe[31:24] inside {8'h00, 8'hff}) // R1
    else $error("direction not uniform within a group");
  AST_DIR_WRITE: assert property (s_dir_write |=> dio_oe == grp_oe($past(pwdata[3:0]))) // R1
    else $error("direction write not applied");
  AST_SCAN_CAPTURE: assert property (clk_en && scan_strobe
      |=> q.scan == $past(q.sync2)) // R3
    else $error("scan capture missed the strobe");
  AST_SYNC_TWO: assert property (clk_en ##1 clk_en |-> q.sync2 == $past(dio_in, 2))
    else $error("input synchroniser depth wrong");
  AST_APB_READY: assert property (s_setup |=> pready ##1 (!pready || !clk_en))
    else $error("apb answer not one access cycle");
  AST_CNT_ROUTE: assert property (q.cfg[0][`DIOC_CFG_A_EN]
      |-> cnt_bus[0].a == q.sync2[q.cfg[0][`DIOC_CFG_A_SEL +: `DIOC_SEL_W]]) // R5
    else $error("counter line routing wrong");

endmodule // dioc_top

// ===== tb/dioc_ext_model.sv
// Purpose: external signals, switches and encoders on the 32 lines
// Assumes: a pull-down holds every line that nobody drives
// Notes:   levels change right after a rising edge of ref_clk
`timescale 1ns/1ps
module dioc_ext_model (
  // clock
  input  wire logic        ref_clk,
  // device pins
  input  wire logic [31:0] dio_out,
  input  wire logic [31:0] dio_oe,
  output logic      [31:0] dio_in
);
  logic [31:0] ext_v;
  logic [31:0] ext_en;

  initial begin
    ext_v = 32'h0;
    ext_en = 32'h0;
  end

  // device wins where it drives, else the source, else the pull-down
  always_comb dio_in = (dio_oe & dio_out) | (~dio_oe & ext_en & ext_v);

  task automatic drive(input logic [31:0] v, input logic [31:0] en);
    @(posedge ref_clk);
    ext_v <= v;
    ext_en <= en;
  endtask

  // each level stands three cycles, so a six-cycle pulse is faster than the 16 MHz pulse limit
  task automatic set2(input int ia, input int ib, input logic [1:0] p);
    @(posedge ref_clk);
    ext_v[ia] <= p[1];
    ext_v[ib] <= p[0];
    ext_en[ia] <= 1'b1;
    ext_en[ib] <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic pulse(input int i, input int n);
    repeat (n) begin
      set2(i, i, 2'h3);
      set2(i, i, 2'h0);
    end
  endtask

  // one full encoder cycle, a leading b when up is set
  task automatic quad(input int ia, input int ib, input logic up);
    logic [7:0] s;
    s = up ? 8'hb4 : 8'h78;
    for (int k = 0; k < 4; k++) begin
      set2(ia, ib, s[7-2*k -: 2]);
    end
  endtask
endmodule // dioc_ext_model

// ===== tb/tb_digital_io_ports_with_counters.sv
// Purpose: self-checking bench of the digital i/o block
// Assumes: zero-wait apb answer, counters fed through the line model
// Notes:   wrap past the top of the range is checked once, on counter 1 in simple mode
`timescale 1ns/1ps
`include "dioc_defines.svh"
module tb_digital_io_ports_with_counters;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] exp;
    logic        err;
  } dioc_row_t;

  logic        ref_clk;
  logic        resetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        scan_strobe;
  logic [31:0] dio_in;
  logic [31:0] dio_out;
  logic [31:0] dio_oe;
  logic [31:0] rd;
  logic        er;
  int          error_cnt;
  int          check_count;
  dioc_row_t   rows [9];

  always #5 ref_clk = ~ref_clk;

  dioc_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .scan_strobe(scan_strobe),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe(dio_oe));

  dioc_ext_model i_ext (.ref_clk(ref_clk), .dio_out(dio_out), .dio_oe(dio_oe),
    .dio_in(dio_in));

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // lets a counter update settle before the read
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] exp);
    repeat (3) @(posedge ref_clk);
    apb(1'b0, a, 32'h0);
    chk(n, rd, exp);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen hang");
    print_verdict;
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    scan_strobe = 1'b0;
    error_cnt = 0;
    check_count = 0;
    rows = '{'{1'b0, `DIOC_OFS_DIR, 32'h0, 32'hc, 1'b0},
             '{1'b1, `DIOC_OFS_OUT, 32'ha5a5_1234, 32'h0, 1'b0},
             '{1'b0, `DIOC_OFS_OUT, 32'h0, 32'ha5a5_1234, 1'b0},
             '{1'b1, `DIOC_OFS_DIR, 32'h5, 32'h0, 1'b0},
             '{1'b0, `DIOC_OFS_DIR, 32'h0, 32'h5, 1'b0},
             '{1'b1, `DIOC_OFS_IN_LIVE, 32'h1, 32'h0, 1'b1},
             '{1'b0, 12'h02c, 32'h0, 32'h0, 1'b1},
             '{1'b1, `DIOC_OFS_VAL0, 32'h7, 32'h0, 1'b1},
             '{1'b0, `DIOC_OFS_CFG0, 32'h0, 32'h0, 1'b0}};
    repeat (5) @(posedge ref_clk);
    chk("dio_oe", dio_oe, 32'hffff_0000);
    chk("dio_out", dio_out, 32'h0);
    resetn <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].w) chk("prdata", rd, rows[i].exp);
    end
    @(posedge ref_clk);
    chk("dio_oe", dio_oe, 32'h00ff_00ff);
    chk("dio_out", dio_out, 32'ha5a5_1234);
    $display("test registers done");
    apb(1'b1, `DIOC_OFS_DIR, 32'h0);
    i_ext.drive(32'h1234_5678, 32'hffff_ffff);
    repeat (4) @(posedge ref_clk);
    scan_strobe <= 1'b1;
    @(posedge ref_clk);
    scan_strobe <= 1'b0;
    i_ext.drive(32'h0f0f_0f0f, 32'hffff_ffff);
    rdchk("in_scan", `DIOC_OFS_IN_SCAN, 32'h1234_5678);
    rdchk("in_live", `DIOC_OFS_IN_LIVE, 32'h0f0f_0f0f);
    i_ext.drive(32'h0, 32'h0);
    $display("test scan done");
    i_ext.pulse(3, 2);
    rdchk("val0", `DIOC_OFS_VAL0, 32'h0);
    apb(1'b1, `DIOC_OFS_CFG0, 32'h0000_0304);
    i_ext.pulse(3, 5);
    rdchk("val0", `DIOC_OFS_VAL0, 32'h5);
    apb(1'b1, `DIOC_OFS_CFG0, 32'h0500_0314);
    i_ext.set2(5, 5, 2'h3);
    i_ext.pulse(3, 2);
    rdchk("val0", `DIOC_OFS_VAL0, 32'h0);
    i_ext.set2(5, 5, 2'h0);
    i_ext.pulse(3, 1);
    rdchk("val0", `DIOC_OFS_VAL0, 32'h1);
    $display("test simple counter done");
    apb(1'b1, `DIOC_OFS_CFG0 + 12'h004, 32'h0015_140d);
    i_ext.set2(21, 21, 2'h3);
    i_ext.pulse(20, 2);
    rdchk("val1", `DIOC_OFS_VAL0 + 12'h004, 32'hffff_fffe);
    i_ext.set2(21, 21, 2'h0);
    i_ext.pulse(20, 3);
    rdchk("val1", `DIOC_OFS_VAL0 + 12'h004, 32'h1);
    // two steps down reach the top of the plain range, then one plain count wraps it
    i_ext.set2(21, 21, 2'h3);
    i_ext.pulse(20, 2);
    rdchk("val1", `DIOC_OFS_VAL0 + 12'h004, 32'hffff_ffff);
    apb(1'b1, `DIOC_OFS_CFG0 + 12'h004, 32'h0015_1404);
    i_ext.pulse(20, 1);
    rdchk("val1", `DIOC_OFS_VAL0 + 12'h004, 32'h0);
    i_ext.set2(21, 21, 2'h0);
    apb(1'b1, `DIOC_OFS_CFG0 + 12'h008, 32'h0009_080e);
    i_ext.quad(8, 9, 1'b1);
    rdchk("val2", `DIOC_OFS_VAL0 + 12'h008, 32'h4);
    i_ext.quad(8, 9, 1'b0);
    i_ext.quad(8, 9, 1'b0);
    rdchk("val2", `DIOC_OFS_VAL0 + 12'h008, 32'hffff_fffc);
    rdchk("val0", `DIOC_OFS_VAL0, 32'h1);
    $display("test up/down and quadrature done");
    print_verdict;
  end
endmodule // tb_digital_io_ports_with_counters
